// ===== hdl/bwc_regs.svh
`ifndef BWC_REGS_SVH
`define BWC_REGS_SVH
// Task-file register selects on the three address lines.
`define BWC_TF_DATA 3'h0
`define BWC_TF_ERRFEAT 3'h1
`define BWC_TF_COUNT 3'h2
`define BWC_TF_LOW 3'h3
`define BWC_TF_MID 3'h4
`define BWC_TF_HIGH 3'h5
`define BWC_TF_DSEL 3'h6
`define BWC_TF_CMDSTAT 3'h7
// Command codes.
`define BWC_CMD_WRITE28 8'hc5
`define BWC_CMD_WRITE48 8'h39
// Drive-state bit positions.
`define BWC_ST_BUSY 7
`define BWC_ST_DRIVE_READY_FLAG 6
`define BWC_ST_FAULT 5
`define BWC_ST_DRQ 3
`define BWC_ST_ERR 0
// Error-flag bit positions.
`define BWC_ER_WP 6
`define BWC_ER_MC 5
`define BWC_ER_ADDRESS_NOT_FOUND_FLAG 4
`define BWC_ER_MCR 3
`define BWC_ER_ABORTED_FLAG 2
`define BWC_ER_NM 1
// Drive-select bit positions.
`define BWC_DS_LBA 6
`define BWC_DS_DEV 4
// Sector geometry and counts.
`define BWC_WORD_LAST 8'hff
`define BWC_COUNT28_ZERO 17'h00100
`define BWC_COUNT48_ZERO 17'h10000
`define BWC_SETUP_LAST 4'h9
`endif

// ===== hdl/bwc_pkg.sv
package bwc_pkg;
   typedef enum logic [2:0] {
      DEV_IDLE = 3'b001,
      DEV_XFER = 3'b010,
      DEV_FLUSH = 3'b100
   } bwc_dev_state_t;
   typedef enum logic [4:0] {
      HST_IDLE = 5'b00001,
      HST_SETUP = 5'b00010,
      HST_POLL = 5'b00100,
      HST_EVAL = 5'b01000,
      HST_DATA = 5'b10000
   } bwc_host_state_t;
endpackage

// ===== hdl/bwc_if.sv
`timescale 1ns/1ps
interface bwc_if;
   logic [2:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic rd;
   logic hob;
   logic [15:0] rdata;
   logic interrupt_request;
   modport host (output addr, output wdata, output wr, output rd, output hob,
      input rdata, input interrupt_request);
   modport dev (input addr, input wdata, input wr, input rd, input hob,
      output rdata, output interrupt_request);
endinterface

// ===== hdl/bwc_device.sv
`timescale 1ns/1ps
`include "bwc_regs.svh"
module bwc_device #(
   parameter logic [7:0] DEFAULT_BLOCK = 8'h10,
   parameter bit DEV_ID = 1'b0,
   parameter bit PACKET_DEV = 1'b0
) (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Task-file side.
   bwc_if.dev tf,
   // Block-size setup state.
   input wire logic setmul_valid_in,
   input wire logic [7:0] setmul_count_in,
   input wire logic multiple_enable_in,
   // Media state.
   input wire logic [47:0] max_lba_in,
   input wire logic write_protect_in,
   input wire logic no_media_in,
   input wire logic media_changed_in,
   input wire logic change_req_in,
   input wire logic fault_in,
   input wire logic media_err_in,
   // Sector data toward the media.
   output logic [15:0] sec_data_out,
   output logic sec_valid_out,
   output logic sec_last_out,
   output logic [47:0] sec_lba_out
);
   if (DEFAULT_BLOCK == 8'h00) begin : g_bad_block
      $error("DEFAULT_BLOCK must be nonzero");
   end

   ////////////////////////////////////////////////////////////////////////////
   bwc_pkg::bwc_dev_state_t state_q;
   logic [7:0] feature_select_q;
   logic [7:0] cnt_cur_q, cnt_prv_q, low_cur_q, low_prv_q;
   logic [7:0] mid_cur_q, mid_prv_q, high_cur_q, high_prv_q;
   logic [7:0] drive_select_q, error_flags_q, bsize_q, blk_left_q, word_q;
   logic [16:0] rem_q;
   logic [47:0] lba_q, fail_lba_q;
   logic ext_q, fail_q, fault_flag_q, mc_latch_q, mcr_q, interrupt_request_q;
   logic [15:0] rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Command decode and start checks.
   wire selected = (drive_select_q[`BWC_DS_DEV] == DEV_ID);
   wire idle = (state_q == bwc_pkg::DEV_IDLE);
   wire cmd_wr = tf.wr && tf.addr == `BWC_TF_CMDSTAT && idle && selected;
   wire is28 = !PACKET_DEV && tf.wdata[7:0] == `BWC_CMD_WRITE28;
   wire is48 = !PACKET_DEV && tf.wdata[7:0] == `BWC_CMD_WRITE48;
   wire [15:0] cnt48 = {cnt_prv_q, cnt_cur_q};
   wire [16:0] cnt28_n = (cnt_cur_q == 8'h00) ? `BWC_COUNT28_ZERO
      : {9'h000, cnt_cur_q};
   wire [16:0] cnt48_n = (cnt48 == 16'h0000) ? `BWC_COUNT48_ZERO : {1'b0, cnt48};
   wire [16:0] nsec = is48 ? cnt48_n : cnt28_n;
   wire [47:0] lba48 = {high_prv_q, mid_prv_q, low_prv_q, high_cur_q, mid_cur_q,
      low_cur_q};
   wire [47:0] lba28 = {20'h00000, drive_select_q[3:0], high_cur_q, mid_cur_q,
      low_cur_q};
   wire [47:0] start_lba = is48 ? lba48 : lba28;
   wire [47:0] end_lba = start_lba + {31'h0, nsec} - 48'h1;
   wire [7:0] bsize = (setmul_valid_in && setmul_count_in != 8'h00) ? setmul_count_in
      : DEFAULT_BLOCK;
   wire abort_start = !(is28 || is48) || !multiple_enable_in
      || !drive_select_q[`BWC_DS_LBA];
   wire out_of_range = end_lba > max_lba_in || end_lba < start_lba;
   logic [7:0] start_err;
   always_comb begin
      start_err = 8'h00;
      start_err[`BWC_ER_ABORTED_FLAG] = abort_start;
      start_err[`BWC_ER_WP] = write_protect_in;
      start_err[`BWC_ER_MC] = mc_latch_q;
      start_err[`BWC_ER_NM] = no_media_in;
      start_err[`BWC_ER_MCR] = mcr_q || change_req_in;
      start_err[`BWC_ER_ADDRESS_NOT_FOUND_FLAG] = !abort_start && out_of_range;
   end
   wire start_ok = cmd_wr && start_err == 8'h00;
   wire start_bad = cmd_wr && start_err != 8'h00;
   wire [7:0] first_blk = (nsec < {9'h000, bsize}) ? nsec[7:0] : bsize;

   ////////////////////////////////////////////////////////////////////////////
   // Data phase: words, sectors and blocks.
   wire data_wr = tf.wr && tf.addr == `BWC_TF_DATA && state_q == bwc_pkg::DEV_XFER;
   wire sec_end = data_wr && word_q == `BWC_WORD_LAST;
   wire blk_end = sec_end && blk_left_q == 8'h01;
   wire [7:0] next_blk = (rem_q < {9'h000, bsize_q}) ? rem_q[7:0] : bsize_q;
   wire flush = state_q == bwc_pkg::DEV_FLUSH;
   wire fin_bad = flush && (fail_q || fault_flag_q);
   wire fin_ok = flush && !fail_q && !fault_flag_q && rem_q == 17'h0;
   wire next_go = flush && !fail_q && !fault_flag_q && rem_q != 17'h0;
   wire stat_rd = tf.rd && tf.addr == `BWC_TF_CMDSTAT;
   wire tf_wr_reg = tf.wr && idle && tf.addr != `BWC_TF_DATA && tf.addr != `BWC_TF_CMDSTAT;
   wire [47:0] err_lba = fail_q ? fail_lba_q : lba_q;

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= bwc_pkg::DEV_IDLE;
      end else if (start_ok || next_go) begin
         state_q <= bwc_pkg::DEV_XFER;
      end else if (blk_end) begin
         state_q <= bwc_pkg::DEV_FLUSH;
      end else if (fin_bad || fin_ok) begin
         state_q <= bwc_pkg::DEV_IDLE;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rem_q <= 17'h0;
         blk_left_q <= 8'h00;
         word_q <= 8'h00;
         bsize_q <= 8'h01;
         lba_q <= 48'h0;
         ext_q <= 1'b0;
      end else if (start_ok) begin
         rem_q <= nsec;
         blk_left_q <= first_blk;
         word_q <= 8'h00;
         bsize_q <= bsize;
         lba_q <= start_lba;
         ext_q <= is48;
      end else if (next_go) begin
         blk_left_q <= next_blk;
      end else if (data_wr) begin
         word_q <= word_q + 8'h01;
         if (sec_end) begin
            rem_q <= rem_q - 17'h1;
            blk_left_q <= blk_left_q - 8'h01;
            lba_q <= lba_q + 48'h1;
         end
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         fail_q <= 1'b0;
         fail_lba_q <= 48'h0;
         fault_flag_q <= 1'b0;
      end else begin
         if (start_ok) begin
            fail_q <= 1'b0;
         end else if (sec_end && media_err_in && !fail_q) begin
            fail_q <= 1'b1;
            fail_lba_q <= lba_q;
         end
         if (cmd_wr) begin
            fault_flag_q <= 1'b0;
         end else if (fault_in && !idle) begin
            fault_flag_q <= 1'b1;
         end
      end
   end

   // A change event in the same cycle as the report is kept for the next command.
   // The write command is a media access, so it clears the request after reporting it.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         mc_latch_q <= 1'b0;
         mcr_q <= 1'b0;
      end else begin
         if (media_changed_in) begin
            mc_latch_q <= 1'b1;
         end else if (cmd_wr) begin
            mc_latch_q <= 1'b0;
         end
         if (change_req_in) begin
            mcr_q <= 1'b1;
         end else if (cmd_wr) begin
            mcr_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error flags and interrupt.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         error_flags_q <= 8'h00;
      end else if (start_bad) begin
         error_flags_q <= start_err;
      end else if (start_ok) begin
         error_flags_q <= 8'h00;
      end else if (fin_bad) begin
         error_flags_q <= 8'h01 << `BWC_ER_ABORTED_FLAG;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         interrupt_request_q <= 1'b0;
      end else if (next_go || start_ok || fin_ok || fin_bad || start_bad) begin
         interrupt_request_q <= 1'b1;
      end else if (stat_rd || cmd_wr) begin
         interrupt_request_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Task-file registers; each count or address write while idle pushes the old byte to the previous copy.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         {cnt_cur_q, cnt_prv_q, low_cur_q, low_prv_q} <= 32'h0;
         {mid_cur_q, mid_prv_q, high_cur_q, high_prv_q} <= 32'h0;
         drive_select_q <= 8'h00;
         feature_select_q <= 8'h00;
      end else if (fin_bad) begin
         {high_cur_q, mid_cur_q, low_cur_q} <= err_lba[23:0];
         if (ext_q) begin
            {high_prv_q, mid_prv_q, low_prv_q} <= err_lba[47:24];
         end else begin
            drive_select_q[3:0] <= err_lba[27:24];
         end
      end else if (tf_wr_reg) begin
         case (tf.addr)
            `BWC_TF_ERRFEAT: feature_select_q <= tf.wdata[7:0];
            `BWC_TF_COUNT: {cnt_prv_q, cnt_cur_q} <= {cnt_cur_q, tf.wdata[7:0]};
            `BWC_TF_LOW: {low_prv_q, low_cur_q} <= {low_cur_q, tf.wdata[7:0]};
            `BWC_TF_MID: {mid_prv_q, mid_cur_q} <= {mid_cur_q, tf.wdata[7:0]};
            `BWC_TF_HIGH: {high_prv_q, high_cur_q} <= {high_cur_q, tf.wdata[7:0]};
            `BWC_TF_DSEL: drive_select_q <= tf.wdata[7:0];
            default: drive_select_q <= drive_select_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path, one cycle after the strobe.
   logic [7:0] drive_state;
   always_comb begin
      drive_state = 8'h00;
      drive_state[`BWC_ST_BUSY] = flush;
      drive_state[`BWC_ST_DRIVE_READY_FLAG] = 1'b1;
      drive_state[`BWC_ST_FAULT] = fault_flag_q && idle;
      drive_state[`BWC_ST_DRQ] = state_q == bwc_pkg::DEV_XFER;
      drive_state[`BWC_ST_ERR] = idle && error_flags_q != 8'h00;
   end
   logic [7:0] rd_byte;
   always_comb begin
      case (tf.addr)
         `BWC_TF_ERRFEAT: rd_byte = idle ? error_flags_q : 8'h00;
         `BWC_TF_COUNT: rd_byte = tf.hob ? cnt_prv_q : cnt_cur_q;
         `BWC_TF_LOW: rd_byte = tf.hob ? low_prv_q : low_cur_q;
         `BWC_TF_MID: rd_byte = tf.hob ? mid_prv_q : mid_cur_q;
         `BWC_TF_HIGH: rd_byte = tf.hob ? high_prv_q : high_cur_q;
         `BWC_TF_DSEL: rd_byte = drive_select_q;
         `BWC_TF_CMDSTAT: rd_byte = drive_state;
         default: rd_byte = 8'h00;
      endcase
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_q <= 16'h0000;
      end else if (tf.rd) begin
         rdata_q <= {8'h00, rd_byte};
      end
   end
   assign tf.rdata = rdata_q;
   assign tf.interrupt_request = interrupt_request_q;

   ////////////////////////////////////////////////////////////////////////////
   // Sector stream toward the media, registered.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sec_data_out <= 16'h0000;
         sec_valid_out <= 1'b0;
         sec_last_out <= 1'b0;
         sec_lba_out <= 48'h0;
      end else begin
         sec_valid_out <= data_wr;
         sec_last_out <= sec_end;
         if (data_wr) begin
            sec_data_out <= tf.wdata;
            sec_lba_out <= lba_q;
         end
      end
   end
endmodule // bwc_device

// ===== hdl/bwc_host.sv
`timescale 1ns/1ps
`include "bwc_regs.svh"
module bwc_host (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Task-file side.
   bwc_if.host tf,
   // Command request.
   input wire logic cmd_start_in,
   input wire logic cmd_ext_in,
   input wire logic [47:0] lba_in,
   input wire logic [15:0] count_in,
   input wire logic [7:0] block_size_in,
   input wire logic dev_in,
   // Write data.
   input wire logic [15:0] wdata_in,
   input wire logic wvalid_in,
   output logic wready_out,
   // Result.
   output logic busy_out,
   output logic done_out,
   output logic error_out,
   output logic [7:0] status_out
);
   bwc_pkg::bwc_host_state_t state_q;
   logic started_q, ext_q, dev_q;
   logic [3:0] step_q;
   logic [47:0] lba_q;
   logic [15:0] count_q;
   logic [16:0] rem_q;
   logic [7:0] bsize_q, blk_left_q, word_q;

   wire count_zero = ext_q ? (count_q == 16'h0000) : (count_q[7:0] == 8'h00);
   wire [16:0] count_n = count_zero ? (ext_q ? `BWC_COUNT48_ZERO
      : `BWC_COUNT28_ZERO) : (ext_q ? {1'b0, count_q} : {9'h000, count_q[7:0]});
   wire [7:0] blk_n = (rem_q < {9'h000, bsize_q}) ? rem_q[7:0] : bsize_q;
   wire [7:0] st = tf.rdata[7:0];
   wire eval = state_q == bwc_pkg::HST_EVAL;
   wire st_busy = st[`BWC_ST_BUSY];
   wire go_setup = eval && !started_q && !st_busy && st[`BWC_ST_DRIVE_READY_FLAG];
   wire go_data = eval && started_q && !st_busy && st[`BWC_ST_DRQ];
   wire go_end = eval && started_q && !st_busy && !st[`BWC_ST_DRQ];
   wire data_wr = state_q == bwc_pkg::HST_DATA && wvalid_in;
   wire blk_done = data_wr && word_q == `BWC_WORD_LAST && blk_left_q == 8'h01;

   // Setup order: for each register the previous byte then the current, then select and command.
   logic [2:0] s_addr;
   logic [7:0] s_data;
   always_comb begin
      case (step_q)
         4'h0: begin s_addr = `BWC_TF_COUNT; s_data = count_q[15:8]; end
         4'h1: begin s_addr = `BWC_TF_COUNT; s_data = count_q[7:0]; end
         4'h2: begin s_addr = `BWC_TF_LOW; s_data = lba_q[31:24]; end
         4'h3: begin s_addr = `BWC_TF_LOW; s_data = lba_q[7:0]; end
         4'h4: begin s_addr = `BWC_TF_MID; s_data = lba_q[39:32]; end
         4'h5: begin s_addr = `BWC_TF_MID; s_data = lba_q[15:8]; end
         4'h6: begin s_addr = `BWC_TF_HIGH; s_data = lba_q[47:40]; end
         4'h7: begin s_addr = `BWC_TF_HIGH; s_data = lba_q[23:16]; end
         4'h8: begin
            s_addr = `BWC_TF_DSEL;
            s_data = {1'b0, 1'b1, 1'b0, dev_q, ext_q ? 4'h0 : lba_q[27:24]};
         end
         default: begin
            s_addr = `BWC_TF_CMDSTAT;
            s_data = ext_q ? `BWC_CMD_WRITE48 : `BWC_CMD_WRITE28;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= bwc_pkg::HST_IDLE;
      end else begin
         case (state_q)
            bwc_pkg::HST_IDLE: if (cmd_start_in) state_q <= bwc_pkg::HST_POLL;
            bwc_pkg::HST_SETUP: if (step_q == `BWC_SETUP_LAST) state_q <= bwc_pkg::HST_POLL;
            bwc_pkg::HST_POLL: state_q <= bwc_pkg::HST_EVAL;
            bwc_pkg::HST_EVAL: begin
               if (go_setup) begin
                  state_q <= bwc_pkg::HST_SETUP;
               end else if (go_data) begin
                  state_q <= bwc_pkg::HST_DATA;
               end else if (go_end) begin
                  state_q <= bwc_pkg::HST_IDLE;
               end else begin
                  state_q <= bwc_pkg::HST_POLL;
               end
            end
            bwc_pkg::HST_DATA: if (blk_done) state_q <= bwc_pkg::HST_POLL;
            default: state_q <= bwc_pkg::HST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         {started_q, ext_q, dev_q} <= 3'b000;
         step_q <= 4'h0;
         lba_q <= 48'h0;
         count_q <= 16'h0000;
         rem_q <= 17'h0;
         bsize_q <= 8'h01;
         blk_left_q <= 8'h00;
         word_q <= 8'h00;
      end else if (state_q == bwc_pkg::HST_IDLE && cmd_start_in) begin
         {started_q, ext_q, dev_q} <= {1'b0, cmd_ext_in, dev_in};
         step_q <= 4'h0;
         lba_q <= lba_in;
         count_q <= count_in;
         bsize_q <= (block_size_in == 8'h00) ? 8'h01 : block_size_in;
      end else if (state_q == bwc_pkg::HST_SETUP) begin
         step_q <= step_q + 4'h1;
         started_q <= 1'b1;
         rem_q <= count_n;
      end else if (go_data) begin
         blk_left_q <= blk_n;
         word_q <= 8'h00;
      end else if (data_wr) begin
         word_q <= word_q + 8'h01;
         if (word_q == `BWC_WORD_LAST) begin
            blk_left_q <= blk_left_q - 8'h01;
            rem_q <= rem_q - 17'h1;
         end
      end
   end

   // After an aborted data phase the address registers hold the failing or next unwritten sector; callers retry per sector.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         done_out <= 1'b0;
         error_out <= 1'b0;
         status_out <= 8'h00;
      end else begin
         done_out <= go_end;
         if (go_end) begin
            status_out <= st;
            error_out <= st[`BWC_ST_ERR] || st[`BWC_ST_FAULT];
         end
      end
   end

   assign tf.addr = (state_q == bwc_pkg::HST_SETUP) ? s_addr
      : (state_q == bwc_pkg::HST_DATA) ? `BWC_TF_DATA : `BWC_TF_CMDSTAT;
   assign tf.wdata = (state_q == bwc_pkg::HST_SETUP) ? {8'h00, s_data} : wdata_in;
   assign tf.wr = (state_q == bwc_pkg::HST_SETUP) || data_wr;
   assign tf.rd = state_q == bwc_pkg::HST_POLL;
   assign tf.hob = 1'b0;
   assign wready_out = state_q == bwc_pkg::HST_DATA;
   assign busy_out = state_q != bwc_pkg::HST_IDLE;
endmodule // bwc_host

// ===== verif/bwc_asserts.sv
`timescale 1ns/1ps
`include "bwc_regs.svh"
module bwc_asserts (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Task-file signals.
   input wire logic [2:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic hob,
   input wire logic [15:0] rdata,
   input wire logic interrupt_request
);
   logic [7:0] word_q;
   logic [7:0] word_d;
   wire data_wr = wr && (addr == `BWC_TF_DATA);
   wire reg_wr = wr && (addr != `BWC_TF_DATA);
   wire stat_rd = rd && (addr == `BWC_TF_CMDSTAT);
   wire is_code = (wdata[7:0] == `BWC_CMD_WRITE28) || (wdata[7:0] == `BWC_CMD_WRITE48);
   wire cmd_wr = wr && (addr == `BWC_TF_CMDSTAT) && is_code;
   // Words within the current sector; a poll mid-sector means a torn sector.
   assign word_d = data_wr ? word_q + 8'h01 : word_q;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         word_q <= 8'h00;
      end else begin
         word_q <= word_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   strobe_apart_a: assert property (!(wr && rd)) else $error("strobes overlap");
   hob_low_a: assert property (hob == 1'b0) else $error("previous byte select used");
   cmd_irq_a: assert property (cmd_wr |=> interrupt_request)
      else $error("no interrupt after command");
   irq_hold_a: assert property (interrupt_request && !stat_rd |=> interrupt_request)
      else $error("interrupt dropped without status read");
   sector_whole_a: assert property ((stat_rd || reg_wr) |-> word_q == 8'h00)
      else $error("register access inside a sector");
   rdata_hold_a: assert property (!rd |=> $stable(rdata)) else $error("read data moved");
   idle_ready_a: assert property (stat_rd ##1 (!rdata[`BWC_ST_BUSY] && !rdata[`BWC_ST_DRQ])
      |-> rdata[`BWC_ST_DRIVE_READY_FLAG]) else $error("idle without ready");
   lba_mode_a: assert property (wr && addr == `BWC_TF_DSEL |-> wdata[`BWC_DS_LBA])
      else $error("select written without address mode");
endmodule // bwc_asserts

// ===== verif/tb_block_pio_write_command.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
   $display("wrong value at %0t: result differs", $time); end end
module tb_block_pio_write_command;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic cmd_start = 1'b0;
   logic cmd_ext = 1'b0;
   logic wvalid = 1'b0;
   logic [7:0] flags = 8'h08;
   logic [47:0] lba = 48'h0;
   logic [15:0] cnt = 16'h0001;
   logic [15:0] wdata = 16'h0;
   logic [7:0] bsz = 8'h01;
   logic wready, busy, done, err, sv, sl;
   logic [7:0] status;
   logic [15:0] sd;
   logic [47:0] slba;
   logic [15:0] dq[$];
   bit [31:0] seed = 32'hb18baa3f;
   int mismatches = 0;
   int n_tests = 0;
   int nwords = 0;
   always #2 core_clk_in = ~core_clk_in;
   function automatic bit [31:0] lfsr(input bit [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   bwc_if tf_bus ();
   bwc_host bwc_host_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .tf(tf_bus),
      .cmd_start_in(cmd_start), .cmd_ext_in(cmd_ext), .lba_in(lba), .count_in(cnt),
      .block_size_in(bsz), .dev_in(1'b0), .wdata_in(wdata), .wvalid_in(wvalid),
      .wready_out(wready), .busy_out(busy), .done_out(done), .error_out(err),
      .status_out(status));
   // Flags are {fault, change request, media changed, setup valid, enable, protect,
   // no media, media error}.
   bwc_device #(.DEFAULT_BLOCK(8'h10), .DEV_ID(1'b0), .PACKET_DEV(1'b0)) bwc_device_inst (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .tf(tf_bus), .setmul_valid_in(flags[4]),
      .setmul_count_in(bsz), .multiple_enable_in(flags[3]), .max_lba_in(48'h0000_0fff_ffff),
      .write_protect_in(flags[2]), .no_media_in(flags[1]), .media_changed_in(flags[5]),
      .change_req_in(flags[6]), .fault_in(flags[7]), .media_err_in(flags[0]), .sec_data_out(sd),
      .sec_valid_out(sv), .sec_last_out(sl), .sec_lba_out(slba));
   bwc_asserts bwc_asserts_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
      .addr(tf_bus.addr), .wdata(tf_bus.wdata), .wr(tf_bus.wr), .rd(tf_bus.rd),
      .hob(tf_bus.hob), .rdata(tf_bus.rdata), .interrupt_request(tf_bus.interrupt_request));
   ////////////////////////////////////////////////////////////////////////////////
   // Data is only replaced once the host has taken it, so no word is skipped.
   always @(posedge core_clk_in) begin
      if (wvalid && wready) begin
         dq.push_back(wdata);
      end
      if (!wvalid || wready) begin
         seed <= lfsr(seed);
         wdata <= seed[15:0];
         wvalid <= seed[20] | seed[27] | seed[9];
      end
      if (sv === 1'b1) begin
         `CHK(dq.size() != 0, 1'b1)
         if (dq.size() != 0) begin
            `CHK(sd, dq.pop_front())
         end
         `CHK(slba, lba + 48'(nwords / 256))
         `CHK(sl, 1'(nwords % 256 == 255))
         nwords++;
      end
   end
   task automatic tally_and_finish();
      if (mismatches == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic run(input logic e, input logic [47:0] a, input logic [15:0] c,
         input logic [7:0] b, input logic [7:0] f, input int nsec, input logic [7:0] st);
      int i;
      @(posedge core_clk_in);
      cmd_ext <= e;
      lba <= a;
      cnt <= c;
      bsz <= b;
      flags <= f;
      nwords = 0;
      @(posedge core_clk_in);
      cmd_start <= 1'b1;
      @(posedge core_clk_in);
      cmd_start <= 1'b0;
      for (i = 0; i < 90000; i++) begin
         @(posedge core_clk_in);
         #1;
         if (done === 1'b1) begin
            break;
         end
      end
      if (i == 90000) begin
         mismatches++;
         tally_and_finish();
      end
      repeat (2) @(posedge core_clk_in);
      #1;
      `CHK(busy, 1'b0)
      `CHK(done, 1'b0)
      `CHK(status, st)
      `CHK(err, st[0])
      `CHK(nwords, nsec * 256)
      `CHK(dq.size(), 0)
   endtask
   initial begin
      repeat (8) @(posedge core_clk_in);
      rst_in <= 1'b0;
      run(1'b0, 48'h0000_0123_4567, 16'h0003, 8'h02, 8'h18, 3, 8'h40);
      run(1'b0, 48'h0000_0000_0010, 16'h0002, 8'h02, 8'h38, 0, 8'h41);
      run(1'b0, 48'h0000_0000_0010, 16'h0002, 8'h02, 8'h58, 0, 8'h41);
      run(1'b0, 48'h0000_0000_0010, 16'h0002, 8'h02, 8'h10, 0, 8'h41);
      run(1'b0, 48'h0000_0000_0010, 16'h0002, 8'h02, 8'h1c, 0, 8'h41);
      run(1'b0, 48'h0000_0000_0010, 16'h0002, 8'h02, 8'h1a, 0, 8'h41);
      run(1'b0, 48'h0000_0000_0020, 16'h0004, 8'h02, 8'h19, 2, 8'h41);
      run(1'b0, 48'h0000_0000_0040, 16'h0004, 8'h02, 8'h98, 2, 8'h61);
      run(1'b0, 48'h0000_0fff_ff40, 16'h0000, 8'h10, 8'h08, 0, 8'h41);
      run(1'b1, 48'h0000_0a5b_3c2d, 16'h0100, 8'h10, 8'h08, 256, 8'h40);
      tally_and_finish();
   end
endmodule // tb_block_pio_write_command
